// File: dlr_byte_if.sv
// Interface carrying reply bytes from sequencer to CRC unit
`default_nettype none
interface dlr_byte_if;
  logic start;
  logic valid;
  logic [7:0] data;
  logic [15:0] crc;
  modport seq (output start, output valid, output data, input crc);
  modport crc_unit (input start, input valid, input data, output crc);
endinterface : dlr_byte_if
`default_nettype wire

// File: dlr_crc16.sv
// CRC accumulator over the bytes of one reply frame
`default_nettype none
module dlr_crc16 #(
  parameter logic [15:0] POLY = dlr_pkg::CRC_POLY,
  parameter logic [15:0] INIT = dlr_pkg::CRC_INIT
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  dlr_byte_if.crc_unit bus
);
  logic [15:0] crc_r;
  logic [15:0] crc_nxt;

  // One byte of MSB-first CRC update
  always_comb
  begin
    crc_nxt = crc_r ^ {bus.data, 8'h00};
    for (int i = 0; i < 8; i++)
    begin
      if (crc_nxt[15])
        crc_nxt = {crc_nxt[14:0], 1'b0} ^ POLY;
      else
        crc_nxt = {crc_nxt[14:0], 1'b0};
    end
  end

  // Restart at frame start, fold in each valid byte
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      crc_r <= 16'hFFFF;
    else if (bus.start)
      crc_r <= INIT;
    else if (bus.valid)
      crc_r <= crc_nxt;
  end

  assign bus.crc = crc_r;
endmodule : dlr_crc16
`default_nettype wire

// File: dlr_master_model.sv
// Model of the debug master taking reply bytes off the link
`default_nettype none
module dlr_master_model (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic slow_in,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rx_q[$];
  // Always ready, or ready every other cycle when slow
  always_ff @(posedge clock_in or posedge sys_rst_in)
    if (sys_rst_in)
      tx_ready_out <= 1'b0;
    else
      tx_ready_out <= slow_in ? !tx_ready_out : 1'b1;
  // Bytes kept for judging; every byte taken is stored whatever the status
  always @(posedge clock_in)
    if (tx_valid_in && tx_ready_out)
      rx_q.push_back(tx_data_in);
  // Bus clock derived from a speed report
  function automatic int bus_freq(input int link_unit_freq, input int cv);
    return 3 * link_unit_freq / (cv - 3);
  endfunction : bus_freq
endmodule : dlr_master_model
`default_nettype wire

// File: dlr_monitor.sv
// Checker of reply framing at the builder's ports
`default_nettype none
module dlr_monitor (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic req_in,
  input wire dlr_pkg::dlr_kind_type kind_in,
  input wire logic addr_error_in,
  input wire logic busy_out,
  input wire logic done_out,
  input wire logic [7:0] tx_data_out,
  input wire logic tx_valid_out,
  input wire logic tx_ready_in,
  input wire logic fuse_programmed_in,
  input wire logic flash_static_reset_in,
  input wire logic access_restricted_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  logic [3:0] idx_r;
  logic [7:0] code_r;
  logic take;
  assign take = req_in && !busy_out;
  // Byte index within the current frame
  always_ff @(posedge clock_in or posedge sys_rst_in)
    if (sys_rst_in)
      idx_r <= 4'h0;
    else if (take)
      idx_r <= 4'h0;
    else if (tx_valid_out && tx_ready_in && idx_r != 4'hF)
      idx_r <= idx_r + 4'h1;
  // Reply code expected for the accepted request
  always_ff @(posedge clock_in or posedge sys_rst_in)
    if (sys_rst_in)
      code_r <= 8'h00;
    else if (take)
      code_r <= (kind_in == dlr_pkg::DLR_K_READ && addr_error_in) ?
        8'hC2 : 8'hC1 + 8'(kind_in);
  a_restrict_level: assert property (
    access_restricted_out == (fuse_programmed_in | flash_static_reset_in))
    else $error("access limit differs from fuse state");
  a_sync_first: assert property (
    take |=> tx_valid_out && tx_data_out == 8'h55)
    else $error("frame did not open with sync byte");
  a_reply_code: assert property (
    busy_out && idx_r == 4'h1 && tx_valid_out |-> tx_data_out == code_r)
    else $error("wrong reply code");
  a_status_len: assert property (
    busy_out && code_r == 8'hC4 && tx_valid_out &&
    (idx_r == 4'h2 || idx_r == 4'h3) |->
    tx_data_out == {6'h00, idx_r == 4'h3, 1'b0})
    else $error("status report length wrong");
  a_offer_holds: assert property (
    tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out))
    else $error("offered byte changed before taken");
  a_idle_quiet: assert property (
    !busy_out |-> !tx_valid_out)
    else $error("byte offered outside a frame");
  a_done_single: assert property (
    done_out |-> !busy_out ##1 !done_out)
    else $error("done not a single idle pulse");
  a_frame_bound: assert property (
    busy_out |-> ##[0:600] !busy_out)
    else $error("frame never ended");
  c_read: cover property (take && kind_in == dlr_pkg::DLR_K_READ);
  c_stall: cover property (tx_valid_out && !tx_ready_in);
  c_done: cover property (done_out);
endmodule : dlr_monitor
bind dlr_response_builder dlr_monitor i_dlr_monitor (
  .clock_in(clock_in), .sys_rst_in(sys_rst_in), .req_in(req_in),
  .kind_in(kind_in), .addr_error_in(addr_error_in), .busy_out(busy_out),
  .done_out(done_out), .tx_data_out(tx_data_out),
  .tx_valid_out(tx_valid_out), .tx_ready_in(tx_ready_in),
  .fuse_programmed_in(fuse_programmed_in),
  .flash_static_reset_in(flash_static_reset_in),
  .access_restricted_out(access_restricted_out));
`default_nettype wire

// File: dlr_pkg.sv
// Package of constants for the debug link response builder
`default_nettype none
package dlr_pkg;
  localparam logic [7:0] SYNC_BYTE = 8'h55;
  localparam logic [7:0] RSP_READ_DATA = 8'hC1;
  localparam logic [7:0] RSP_ACCESS_STATUS = 8'hC2;
  localparam logic [7:0] RSP_BAUD_RATE = 8'hC3;
  localparam logic [7:0] RSP_STATUS_REPORT = 8'hC4;
  localparam logic [7:0] RSP_BUS_SPEED = 8'hC5;
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_BUSY = 8'h01;
  localparam logic [7:0] ST_BUS_ERROR = 8'h02;
  localparam logic [15:0] TRAILER_LEN = 16'h0003;
  localparam logic [15:0] STATUS_REPORT_LEN = 16'h0002;
  localparam int BIT_PROTECTED = 8;
  localparam int BIT_BUS_BUSY = 7;
  localparam int BIT_ERASE_ON = 6;
  localparam int BIT_CPU_HALTED = 5;
  localparam int BIT_RESET_BY_LINK = 0;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam int BAUD_WIDTH = 16;
  localparam int CYCLE_WIDTH = 16;
  // Frame sequencer states, Gray coded along the usual path
  typedef enum logic [3:0] {
    DLR_IDLE = 4'h0,
    DLR_SYNC = 4'h1,
    DLR_CODE = 4'h3,
    DLR_LEN_HI = 4'h2,
    DLR_LEN_LO = 4'h6,
    DLR_PAYLOAD = 4'h7,
    DLR_TRAILER = 4'h5,
    DLR_CRC_HI = 4'h4,
    DLR_CRC_LO = 4'hC
  } dlr_state_type;
  // Reply kinds requested by the command side
  typedef enum logic [2:0] {
    DLR_K_READ = 3'h0,
    DLR_K_WRITE = 3'h1,
    DLR_K_BAUD = 3'h2,
    DLR_K_STATUS = 3'h3,
    DLR_K_SPEED = 3'h4
  } dlr_kind_type;
endpackage : dlr_pkg
`default_nettype wire

// File: dlr_response_builder.sv
// Reply frame builder of the debug link unit reporting access limits
// Contract
// - Frame is sync 0x55, code, 16-bit length MSB first, payload, CRC.
// - Memory read answers code 0xC1, data then status and 2-byte count.
// - Read status byte 0x00 ok, 0x01 busy, 0x02 wrong address.
// - Read count gives bytes left at error, zero on success.
// - Failed read still sends full data field with filler bytes.
// - Status 0x00 means all data valid; master trusts only that.
// - Every memory write is answered with access status code 0xC2.
// - Error while receiving read address gives access status reply.
// - Access status payload is status byte and 2-byte count.
// - Rate query answered with code 0xC3 and current baud setting.
// - Status report code 0xC4, two bytes, reserved bits zero.
// - Bit 8 shows flash protection, reads one during reset.
// - Bit 7 shows internal bus still busy with earlier transfer.
// - Bit 6 shows full-chip erase still in progress.
// - Bit 5 shows processor halted, reads zero during reset.
// - Bit 0 shows link unit reset the processor.
// - Bus-speed report code 0xC5 carries round-trip cycle count.
// - Programmed security fuse restricts memory read and write; here it is only reported on access_restricted_out.
// - Full access returns only after link chip erase clears fuse.
// - Flash controller in static reset counts as fuse programmed.
`default_nettype none
module dlr_response_builder #(
  parameter int BAUD_W = dlr_pkg::BAUD_WIDTH,
  parameter int CYCLE_W = dlr_pkg::CYCLE_WIDTH
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // Reply request from the command side
  input wire logic req_in,
  input wire dlr_pkg::dlr_kind_type kind_in,
  input wire logic [15:0] read_len_in,
  input wire logic addr_error_in,
  input wire logic [7:0] addr_status_in,
  input wire logic [15:0] write_count_in,
  input wire logic [7:0] write_status_in,
  output logic busy_out,
  output logic done_out,
  // Read data supplied by the internal bus side
  input wire logic rd_valid_in,
  input wire logic [7:0] rd_data_in,
  input wire logic rd_error_in,
  input wire logic [7:0] rd_status_in,
  output logic rd_ready_out,
  // Byte stream toward the pin transmitter
  output logic [7:0] tx_data_out,
  output logic tx_valid_out,
  input wire logic tx_ready_in,
  // Live status inputs
  input wire logic [BAUD_W-1:0] baud_in,
  input wire logic [CYCLE_W-1:0] cycle_value_in,
  input wire logic fuse_programmed_in,
  input wire logic flash_static_reset_in,
  input wire logic chip_erase_busy_in,
  input wire logic bus_busy_in,
  input wire logic cpu_halted_in,
  input wire logic cpu_in_reset_in,
  input wire logic link_reset_cpu_in,
  output logic access_restricted_out
);
  // ********************************************
  // Declarations
  // ********************************************
  // Whole bytes needed for the baud and cycle payloads
  localparam int BAUD_BYTES = (BAUD_W + 7) / 8;
  localparam int CYC_BYTES = (CYCLE_W + 7) / 8;
  // Frame registers and combinational signals
  dlr_pkg::dlr_state_type state_r;
  dlr_pkg::dlr_kind_type kind_r;
  logic [7:0] code_r;
  logic [15:0] len_r;
  logic [15:0] data_left_r;
  logic [1:0] trail_idx_r;
  logic read_fail;
  logic [7:0] status_r;
  logic [15:0] count_r;
  logic failed_r;
  logic [47:0] fixed_r;
  logic [7:0] byte_mux;
  logic step;
  logic [15:0] status_word;
  logic restricted;
  dlr_byte_if crc_bus ();

  // ********************************************
  // Security and live status
  // ********************************************
  // Static reset of the flash controller reads as programmed fuse
  assign restricted = fuse_programmed_in | flash_static_reset_in;
  // Blocking itself is left to the command side; this only reports it
  // Fuse input only drops after link chip erase clears it
  assign access_restricted_out = restricted;

  // Two status bytes, reserved bits held at zero
  always_comb
  begin
    status_word = 16'h0000;
    status_word[dlr_pkg::BIT_PROTECTED] = restricted | cpu_in_reset_in;
    status_word[dlr_pkg::BIT_BUS_BUSY] = bus_busy_in;
    status_word[dlr_pkg::BIT_ERASE_ON] = chip_erase_busy_in;
    status_word[dlr_pkg::BIT_CPU_HALTED] = cpu_halted_in & ~cpu_in_reset_in;
    status_word[dlr_pkg::BIT_RESET_BY_LINK] = link_reset_cpu_in;
  end

  // ********************************************
  // Byte selection
  // ********************************************
  // Byte currently offered to the transmitter
  always_comb
  begin
    byte_mux = 8'h00;
    case (state_r)
      dlr_pkg::DLR_SYNC: byte_mux = dlr_pkg::SYNC_BYTE;
      dlr_pkg::DLR_CODE: byte_mux = code_r;
      dlr_pkg::DLR_LEN_HI: byte_mux = len_r[15:8];
      dlr_pkg::DLR_LEN_LO: byte_mux = len_r[7:0];
      dlr_pkg::DLR_PAYLOAD:
        // The failing byte itself already goes out as filler
        if (kind_r == dlr_pkg::DLR_K_READ)
          byte_mux = (failed_r || read_fail) ? 8'h00 : rd_data_in;
        else
          byte_mux = fixed_r[47:40];
      dlr_pkg::DLR_TRAILER:
        if (trail_idx_r == 2'h0)
          byte_mux = status_r;
        else if (trail_idx_r == 2'h1)
          byte_mux = count_r[15:8];
        else
          byte_mux = count_r[7:0];
      dlr_pkg::DLR_CRC_HI: byte_mux = crc_bus.crc[15:8];
      dlr_pkg::DLR_CRC_LO: byte_mux = crc_bus.crc[7:0];
      default: byte_mux = 8'h00;
    endcase
  end

  // Read data only taken while live bytes are still expected and the far side is ready
  assign rd_ready_out = (state_r == dlr_pkg::DLR_PAYLOAD) &&
    (kind_r == dlr_pkg::DLR_K_READ) && !failed_r && tx_ready_in;
  // Error flagged on an offered live read byte
  assign read_fail = (state_r == dlr_pkg::DLR_PAYLOAD) &&
    (kind_r == dlr_pkg::DLR_K_READ) && !failed_r && rd_valid_in &&
    rd_error_in;
  // A live read byte is offered only while the source has one
  assign tx_valid_out = (state_r != dlr_pkg::DLR_IDLE) &&
    !((state_r == dlr_pkg::DLR_PAYLOAD) && (kind_r == dlr_pkg::DLR_K_READ)
      && !failed_r && !rd_valid_in);
  // Byte leaves when the far side takes it
  assign tx_data_out = byte_mux;
  assign step = tx_valid_out && tx_ready_in;
  assign busy_out = (state_r != dlr_pkg::DLR_IDLE);

  // CRC covers every byte from sync through the last payload or trailer byte
  assign crc_bus.start = req_in && (state_r == dlr_pkg::DLR_IDLE);
  assign crc_bus.valid = step && (state_r != dlr_pkg::DLR_CRC_HI) &&
    (state_r != dlr_pkg::DLR_CRC_LO);
  assign crc_bus.data = byte_mux;

  // CRC engine fed from the byte actually offered
  dlr_crc16 u_crc (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .bus(crc_bus.crc_unit)
  );

  // ********************************************
  // Frame setup on request
  // ********************************************
  // Latch reply kind, code, length and fixed payload
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      kind_r <= dlr_pkg::DLR_K_READ;
      code_r <= 8'h00;
      len_r <= 16'h0000;
      fixed_r <= 48'h000000000000;
    end
    else if (crc_bus.start)
    begin
      kind_r <= kind_in;
      fixed_r <= 48'h000000000000;
      case (kind_in)
        dlr_pkg::DLR_K_READ:
          // Failed address turns the read into an access status reply
          if (addr_error_in)
          begin
            kind_r <= dlr_pkg::DLR_K_WRITE;
            code_r <= dlr_pkg::RSP_ACCESS_STATUS;
            len_r <= dlr_pkg::TRAILER_LEN;
          end
          else
          begin
            code_r <= dlr_pkg::RSP_READ_DATA;
            len_r <= 16'(read_len_in + dlr_pkg::TRAILER_LEN);
          end
        dlr_pkg::DLR_K_WRITE:
        begin
          code_r <= dlr_pkg::RSP_ACCESS_STATUS;
          len_r <= dlr_pkg::TRAILER_LEN;
        end
        dlr_pkg::DLR_K_BAUD:
        begin
          code_r <= dlr_pkg::RSP_BAUD_RATE;
          len_r <= 16'(BAUD_BYTES);
          fixed_r <= 48'(baud_in) << (48 - 8 * BAUD_BYTES);
        end
        dlr_pkg::DLR_K_STATUS:
        begin
          code_r <= dlr_pkg::RSP_STATUS_REPORT;
          len_r <= dlr_pkg::STATUS_REPORT_LEN;
          fixed_r <= {status_word, 32'h00000000};
        end
        default:
        begin
          code_r <= dlr_pkg::RSP_BUS_SPEED;
          len_r <= 16'(CYC_BYTES);
          fixed_r <= 48'(cycle_value_in) << (48 - 8 * CYC_BYTES);
        end
      endcase
    end
    else if (step && (state_r == dlr_pkg::DLR_PAYLOAD))
      fixed_r <= {fixed_r[39:0], 8'h00};
  end

  // ********************************************
  // Outcome tracking
  // ********************************************
  // Status and remaining count; first error is kept
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      status_r <= 8'h00;
      count_r <= 16'h0000;
      failed_r <= 1'b0;
    end
    else if (crc_bus.start)
    begin
      failed_r <= 1'b0;
      if (kind_in == dlr_pkg::DLR_K_READ && addr_error_in)
      begin
        status_r <= addr_status_in;
        count_r <= 16'h0000;
      end
      else if (kind_in == dlr_pkg::DLR_K_WRITE)
      begin
        // Write outcome is passed on as given
        status_r <= write_status_in;
        count_r <= write_count_in;
      end
      else
      begin
        status_r <= dlr_pkg::ST_OK;
        count_r <= 16'h0000;
      end
    end
    else if (read_fail)
    begin
      failed_r <= 1'b1;
      status_r <= rd_status_in;
      // Count covers the failing byte, the data bytes after it and the three trailer bytes
      count_r <= 16'(data_left_r + dlr_pkg::TRAILER_LEN);
    end
  end

  // ********************************************
  // Frame sequencer
  // ********************************************
  // Walk sync, code, length, payload, trailer and CRC
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state_r <= dlr_pkg::DLR_IDLE;
      data_left_r <= 16'h0000;
      trail_idx_r <= 2'h0;
    end
    else if (crc_bus.start)
    begin
      state_r <= dlr_pkg::DLR_SYNC;
      trail_idx_r <= 2'h0;
      // Payload bytes per reply kind
      if (kind_in == dlr_pkg::DLR_K_READ && !addr_error_in)
        data_left_r <= read_len_in;
      else if (kind_in == dlr_pkg::DLR_K_BAUD)
        data_left_r <= 16'(BAUD_BYTES);
      else if (kind_in == dlr_pkg::DLR_K_SPEED)
        data_left_r <= 16'(CYC_BYTES);
      else if (kind_in == dlr_pkg::DLR_K_STATUS)
        data_left_r <= dlr_pkg::STATUS_REPORT_LEN;
      else
        data_left_r <= 16'h0000;
    end
    else if (step)
    begin
      case (state_r)
        dlr_pkg::DLR_SYNC: state_r <= dlr_pkg::DLR_CODE;
        dlr_pkg::DLR_CODE: state_r <= dlr_pkg::DLR_LEN_HI;
        dlr_pkg::DLR_LEN_HI: state_r <= dlr_pkg::DLR_LEN_LO;
        dlr_pkg::DLR_LEN_LO:
          // Empty payload goes straight to trailer or CRC
          if (data_left_r != 16'h0000)
            state_r <= dlr_pkg::DLR_PAYLOAD;
          else if (kind_r == dlr_pkg::DLR_K_READ ||
            kind_r == dlr_pkg::DLR_K_WRITE)
            state_r <= dlr_pkg::DLR_TRAILER;
          else
            state_r <= dlr_pkg::DLR_CRC_HI;
        dlr_pkg::DLR_PAYLOAD:
        begin
          data_left_r <= data_left_r - 16'h0001;
          if (data_left_r == 16'h0001)
            state_r <= (kind_r == dlr_pkg::DLR_K_READ) ?
              dlr_pkg::DLR_TRAILER : dlr_pkg::DLR_CRC_HI;
        end
        dlr_pkg::DLR_TRAILER:
        begin
          // Status, count high, count low
          trail_idx_r <= trail_idx_r + 2'h1;
          if (trail_idx_r == 2'h2)
            state_r <= dlr_pkg::DLR_CRC_HI;
        end
        dlr_pkg::DLR_CRC_HI: state_r <= dlr_pkg::DLR_CRC_LO;
        default: state_r <= dlr_pkg::DLR_IDLE;
      endcase
    end
  end

  // ********************************************
  // Reply completion
  // ********************************************
  // One-cycle pulse in the cycle after the last CRC byte is taken
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      done_out <= 1'b0;
    else
      done_out <= step && (state_r == dlr_pkg::DLR_CRC_LO);
  end
endmodule : dlr_response_builder
`default_nettype wire

// File: dlr_response_builder_tb_top.sv
// Testbench of the reply frame builder
`default_nettype none
module dlr_response_builder_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_in = 0, sys_rst_in = 1, req_in = 0, addr_error_in = 0;
  logic rd_valid_in = 1, slow = 0, rd_error_in, rd_ready_out;
  logic busy_out, done_out, tx_valid_out, tx_ready_in, access_restricted_out;
  logic [7:0] addr_status_in = 0, write_status_in = 0, rd_status_in = 0;
  logic [7:0] rd_data_in, tx_data_out;
  logic [15:0] read_len_in = 0, write_count_in = 0, baud_in = 0;
  logic [15:0] cycle_value_in = 0;
  logic [6:0] live = 0;
  dlr_pkg::dlr_kind_type kind_in = dlr_pkg::DLR_K_READ;
  logic [7:0] exp_q[$];
  int rk = 0, err_at = 0, n_errors = 0, total_checks = 0, cyc = 0;
  always #25 clock_in = ~clock_in;
  // Read byte source; error flag rises at the chosen byte
  assign rd_data_in = 8'h3C ^ rk[7:0];
  assign rd_error_in = (rk == err_at);
  always @(posedge clock_in)
    if (rd_valid_in && rd_ready_out)
      rk <= rk + 1;
  // Hang guard
  always @(posedge clock_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      give_verdict();
    end
  end
  dlr_response_builder i_dlr_response_builder (.clock_in(clock_in),
    .sys_rst_in(sys_rst_in), .req_in(req_in), .kind_in(kind_in),
    .read_len_in(read_len_in), .addr_error_in(addr_error_in),
    .addr_status_in(addr_status_in), .write_count_in(write_count_in),
    .write_status_in(write_status_in), .busy_out(busy_out),
    .done_out(done_out), .rd_valid_in(rd_valid_in), .rd_data_in(rd_data_in),
    .rd_error_in(rd_error_in), .rd_status_in(rd_status_in),
    .rd_ready_out(rd_ready_out), .tx_data_out(tx_data_out),
    .tx_valid_out(tx_valid_out), .tx_ready_in(tx_ready_in),
    .baud_in(baud_in), .cycle_value_in(cycle_value_in),
    .fuse_programmed_in(live[0]), .flash_static_reset_in(live[1]),
    .chip_erase_busy_in(live[2]), .bus_busy_in(live[3]),
    .cpu_halted_in(live[4]), .cpu_in_reset_in(live[5]),
    .link_reset_cpu_in(live[6]), .access_restricted_out(access_restricted_out));
  dlr_master_model i_dlr_master_model (.clock_in(clock_in),
    .sys_rst_in(sys_rst_in), .slow_in(slow), .tx_data_in(tx_data_out),
    .tx_valid_in(tx_valid_out), .tx_ready_out(tx_ready_in));
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask : chk1
  function automatic logic [15:0] crc_step(input logic [15:0] c,
    input logic [7:0] b);
    c = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++)
      c = c[15] ? (c << 1) ^ dlr_pkg::CRC_POLY : c << 1;
    return c;
  endfunction : crc_step
  task automatic head(input logic [7:0] code, input logic [15:0] len);
    exp_q = {8'h55, code, len[15:8], len[7:0]};
  endtask : head
  // Adds CRC, requests a frame, waits for done, compares bytes
  task automatic run_frame(input dlr_pkg::dlr_kind_type k, input int upto);
    logic [15:0] c;
    int n;
    c = dlr_pkg::CRC_INIT;
    foreach (exp_q[i]) c = crc_step(c, exp_q[i]);
    exp_q.push_back(c[15:8]);
    exp_q.push_back(c[7:0]);
    i_dlr_master_model.rx_q.delete();
    req_in <= 1'b1;
    kind_in <= k;
    @(posedge clock_in);
    req_in <= 1'b0;
    n = 0;
    while (done_out !== 1'b1 && n < 600)
    begin
      @(posedge clock_in);
      n++;
    end
    chk1(busy_out, 1'b0);
    chk8(8'(i_dlr_master_model.rx_q.size()), 8'(exp_q.size()));
    foreach (exp_q[i])
      if (i < upto) chk8(i_dlr_master_model.rx_q[i], exp_q[i]);
  endtask : run_frame
  task automatic t_read(input logic [15:0] len, input int err,
    input logic [7:0] st, input logic s);
    logic [15:0] left;
    left = (err < len) ? len + 16'h3 - 16'(err) : 16'h0;
    @(posedge clock_in);
    read_len_in <= len;
    rd_status_in <= st;
    err_at <= err;
    rk <= 0;
    slow <= s;
    head(8'hC1, len + 16'h3);
    for (int i = 0; i < len; i++)
      exp_q.push_back(i < err ? 8'h3C ^ 8'(i) : 8'h00);
    exp_q.push_back(err < len ? st : 8'h00);
    exp_q.push_back(left[15:8]);
    exp_q.push_back(left[7:0]);
    run_frame(dlr_pkg::DLR_K_READ, 99);
    $display("read test done");
  endtask : t_read
  task automatic t_write();
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clock_in);
      write_status_in <= 8'(i);
      write_count_in <= 16'h0A00 + 16'(i);
      head(8'hC2, 16'h3);
      exp_q.push_back(8'(i));
      exp_q.push_back(8'h0A);
      exp_q.push_back(8'(i));
      run_frame(dlr_pkg::DLR_K_WRITE, 99);
    end
    $display("write test done");
  endtask : t_write
  task automatic t_addr_err();
    @(posedge clock_in);
    addr_error_in <= 1'b1;
    addr_status_in <= 8'h02;
    head(8'hC2, 16'h3);
    exp_q.push_back(8'h02);
    exp_q.push_back(8'h00);
    exp_q.push_back(8'h00);
    run_frame(dlr_pkg::DLR_K_READ, 99);
    addr_error_in <= 1'b0;
    $display("address error test done");
  endtask : t_addr_err
  task automatic t_word(input dlr_pkg::dlr_kind_type k,
    input logic [15:0] v);
    logic [15:0] e;
    e = (k == dlr_pkg::DLR_K_BAUD) ? v : ~v;
    @(posedge clock_in);
    baud_in <= v;
    cycle_value_in <= ~v;
    head(8'hC1 + 8'(k), 16'h2);
    exp_q.push_back(e[15:8]);
    exp_q.push_back(e[7:0]);
    run_frame(k, 99);
    $display("word report test done");
  endtask : t_word
  task automatic t_status();
    logic [15:0] s;
    logic [6:0] v;
    for (int i = 0; i < 9; i++)
    begin
      v = (i < 7) ? 7'h01 << i : (i == 7 ? 7'h7F : 7'h00);
      s = {7'h00, v[0] | v[1] | v[5], v[3], v[2], v[4] & !v[5], 4'h0, v[6]};
      @(posedge clock_in);
      live <= v;
      slow <= i[0];
      head(8'hC4, 16'h2);
      exp_q.push_back(s[15:8]);
      exp_q.push_back(s[7:0]);
      run_frame(dlr_pkg::DLR_K_STATUS, 99);
      chk8(i_dlr_master_model.rx_q[5], s[7:0]);
      chk1(access_restricted_out, v[0] | v[1]);
    end
    $display("status report test done");
  endtask : t_status
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict
  initial
  begin
    repeat (8) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    t_read(16'h4, 4, 8'h00, 1'b0);
    t_read(16'h4, 2, 8'h02, 1'b1);
    t_read(16'h1, 0, 8'h01, 1'b0);
    t_write();
    t_addr_err();
    t_word(dlr_pkg::DLR_K_BAUD, 16'h1234);
    t_word(dlr_pkg::DLR_K_SPEED, 16'h00A7);
    t_status();
    give_verdict();
  end
endmodule : dlr_response_builder_tb_top
`default_nettype wire
